// ---- strap_pin_pkg.sv ----
// Package with constants and carrier types for the strap-controlled pin function block.
package strap_pin_pkg;
  localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
  localparam logic [7:0] OFS_SMB_ADDR = 8'h04;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h08;
  localparam logic [7:0] OFS_GPIO_OE = 8'h0c;
  localparam logic [7:0] OFS_PIN_IN = 8'h10;
  localparam logic [7:0] OFS_GEN_OUT = 8'h14;
  localparam int STS_HOTPLUG_BIT = 0;
  localparam int STS_MGMT_SEL_BIT = 1;
  localparam int STS_TEST_HI_BIT = 2;
  localparam int STS_EXT_ARB_BIT = 3;
  localparam int STS_LOCKED_BIT = 4;
  localparam int STS_SMBUS_BIT = 5;
  localparam int STS_EEPROM_BIT = 6;
  localparam int PIN_IN_GEN_LSB = 4;
  localparam logic [2:0] SMB_ADDR_FIXED = 3'h6;
  localparam logic [3:0] GPIO_OUT_RESET = 4'h0;
  localparam logic [3:0] GPIO_OE_RESET = 4'h0;
  localparam logic [3:0] GEN_OUT_RESET = 4'h0;
  localparam int SYNC_DEPTH = 3;
  localparam real SETTLE_NS = 30.0;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int SETTLE_CYCLES = int'($ceil(SETTLE_NS / CLK_PERIOD_NS));
  localparam int PIN_W = 14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic hotplug;
    logic mgmt_sel;
    logic test_hi;
    logic ext_arb;
  } strap_type;

  typedef struct packed {
    logic sda;
    logic scl;
    logic [3:0] req_n;
    logic [3:0] gpio;
    strap_type straps;
  } pins_type;

  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_SETTLE = 2'h1,
    ST_LOCKED = 2'h3
  } lock_state_type;
endpackage

// ---- strap_pin_function_select.sv ----
// Strap sampling, pin function multiplexing and register slave for general-purpose pins.
//
// Contract
// - Hot-plug strap high at reset gives general-purpose pins 3..1 to hot-plug signalling.
// - Management select strap at 1 with test strap low makes general-purpose pins 3..0 SMBus address bits.
// - SMBus address bits 7..1 are 1,1,0 then general-purpose pins 3..0 in order.
// - External arbiter strap high provides four general-purpose inputs and four outputs.
// - Then request inputs 5..2 become inputs 3..0, grants 5..2 become outputs 3..0.
// - Management select strap counts only with test strap low: 0 serial memory, 1 SMBus.
// - In SMBus mode clock pin is input only; data pin is driven only low.
`timescale 1ns/100ps
module strap_pin_function_select
  import strap_pin_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Strap pins.
  input wire logic hotplug_mask_strap,
  input wire logic mgmt_bus_select_strap,
  input wire logic test_mode_strap_hi,
  input wire logic ext_arbiter_select_strap,
  // General-purpose pins.
  input wire logic [3:0] gpio_pin_in,
  output logic [3:0] gpio_pin_out,
  output logic [3:0] gpio_pin_oe,
  // Arbitration pins.
  input wire logic [5:2] req_n_pin,
  output logic [5:2] gnt_n_pin,
  // Management serial pins.
  input wire logic mgmt_serial_clock_pin_in,
  output logic mgmt_serial_clock_pin_out,
  output logic mgmt_serial_clock_pin_oe,
  input wire logic mgmt_serial_data_pin_in,
  output logic mgmt_serial_data_pin_out,
  output logic mgmt_serial_data_pin_oe,
  // Core side.
  input wire logic [3:1] hp_core_out,
  input wire logic [3:1] hp_core_oe,
  output logic [3:1] hp_core_in,
  input wire logic [5:2] arb_core_gnt_n,
  output logic [5:2] arb_core_req_n,
  input wire logic mgmt_core_clock_out,
  input wire logic mgmt_core_data_out,
  input wire logic mgmt_core_data_oe,
  output logic mgmt_core_clock_in,
  output logic mgmt_core_data_in,
  output strap_type strap_q,
  output logic smbus_mode_q,
  output logic eeprom_mode_q,
  output logic [7:1] smbus_target_addr_q,
  output logic straps_locked
);

  // A bit changes only when the second and third stages agree.
  function automatic pins_type filt(pins_type prev, pins_type s2, pins_type s3);
    filt = (s2 & s3) | (prev & (s2 | s3));
  endfunction

  // Seven-bit SMBus address from the four general-purpose pins.
  function automatic logic [7:1] smb_addr(logic [3:0] pins);
    smb_addr = {SMB_ADDR_FIXED, pins};
  endfunction

  pins_type raw;
  pins_type s1_q, s2_q, s3_q, filt_q;
  lock_state_type state_q;
  logic [1:0] settle_q;
  logic [3:0] gpio_out_q, gpio_oe_q, gen_out_q;
  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [31:0] rd_data;
  logic rd_hit;

  assign raw = {mgmt_serial_data_pin_in, mgmt_serial_clock_pin_in, req_n_pin, gpio_pin_in,
                hotplug_mask_strap, mgmt_bus_select_strap, test_mode_strap_hi,
                ext_arbiter_select_strap};
  assign straps_locked = (state_q == ST_LOCKED);

  // Three-stage synchroniser; only the second and third stages feed the filter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt(filt_q, s2_q, s3_q);
    end
  end

  // Straps are captured once after the filter settles and then held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RESET;
      settle_q <= '0;
      strap_q <= '0;
      smbus_mode_q <= 1'b0;
      eeprom_mode_q <= 1'b0;
      smbus_target_addr_q <= '0;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_q <= ST_SETTLE;
        end
        ST_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == 2'(SETTLE_CYCLES)) begin
            state_q <= ST_LOCKED;
            strap_q <= filt_q.straps;
            smbus_mode_q <= filt_q.straps.mgmt_sel & ~filt_q.straps.test_hi;
            eeprom_mode_q <= ~filt_q.straps.mgmt_sel & ~filt_q.straps.test_hi;
            if (filt_q.straps.mgmt_sel & ~filt_q.straps.test_hi) begin
              smbus_target_addr_q <= smb_addr(filt_q.gpio);
            end
          end
        end
        ST_LOCKED: begin
          state_q <= ST_LOCKED;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // Pin multiplexing; all pin and core outputs are registered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_pin_out <= '0;
      gpio_pin_oe <= '0;
      hp_core_in <= '0;
      gnt_n_pin <= '1;
      arb_core_req_n <= '1;
      mgmt_serial_clock_pin_out <= 1'b0;
      mgmt_serial_clock_pin_oe <= 1'b0;
      mgmt_serial_data_pin_out <= 1'b0;
      mgmt_serial_data_pin_oe <= 1'b0;
      mgmt_core_clock_in <= 1'b1;
      mgmt_core_data_in <= 1'b1;
    end else begin
      gpio_pin_out[0] <= gpio_out_q[0];
      gpio_pin_oe[0] <= gpio_oe_q[0];
      if (strap_q.hotplug) begin
        gpio_pin_out[3:1] <= hp_core_out;
        gpio_pin_oe[3:1] <= hp_core_oe;
        hp_core_in <= filt_q.gpio[3:1];
      end else begin
        gpio_pin_out[3:1] <= gpio_out_q[3:1];
        gpio_pin_oe[3:1] <= gpio_oe_q[3:1];
        hp_core_in <= '0;
      end
      if (strap_q.ext_arb) begin
        gnt_n_pin <= gen_out_q;
        arb_core_req_n <= '1;
      end else begin
        gnt_n_pin <= arb_core_gnt_n;
        arb_core_req_n <= filt_q.req_n;
      end
      mgmt_core_clock_in <= filt_q.scl;
      mgmt_core_data_in <= filt_q.sda;
      if (smbus_mode_q) begin
        mgmt_serial_clock_pin_out <= 1'b0;
        mgmt_serial_clock_pin_oe <= 1'b0;
        mgmt_serial_data_pin_out <= 1'b0;
        mgmt_serial_data_pin_oe <= mgmt_core_data_oe & ~mgmt_core_data_out;
      end else if (eeprom_mode_q) begin
        mgmt_serial_clock_pin_out <= mgmt_core_clock_out;
        mgmt_serial_clock_pin_oe <= 1'b1;
        mgmt_serial_data_pin_out <= mgmt_core_data_out;
        mgmt_serial_data_pin_oe <= mgmt_core_data_oe;
      end else begin
        mgmt_serial_clock_pin_out <= 1'b0;
        mgmt_serial_clock_pin_oe <= 1'b0;
        mgmt_serial_data_pin_out <= 1'b0;
        mgmt_serial_data_pin_oe <= 1'b0;
      end
    end
  end

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case ({awaddr_q[7:2], 2'h0})
          OFS_STRAP_STATUS, OFS_SMB_ADDR, OFS_GPIO_OUT, OFS_GPIO_OE, OFS_PIN_IN,
          OFS_GEN_OUT: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-writable pin registers; only byte lane 0 carries bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_out_q <= GPIO_OUT_RESET;
      gpio_oe_q <= GPIO_OE_RESET;
      gen_out_q <= GEN_OUT_RESET;
    end else if (wr_fire & wstrb_q[0]) begin
      if ({awaddr_q[7:2], 2'h0} == OFS_GPIO_OUT) begin
        gpio_out_q <= wdata_q[3:0];
      end
      if ({awaddr_q[7:2], 2'h0} == OFS_GPIO_OE) begin
        gpio_oe_q <= wdata_q[3:0];
      end
      if ({awaddr_q[7:2], 2'h0} == OFS_GEN_OUT) begin
        gen_out_q <= wdata_q[3:0];
      end
    end
  end

  // Read decode.
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      OFS_STRAP_STATUS: begin
        rd_data[STS_HOTPLUG_BIT] = strap_q.hotplug;
        rd_data[STS_MGMT_SEL_BIT] = strap_q.mgmt_sel;
        rd_data[STS_TEST_HI_BIT] = strap_q.test_hi;
        rd_data[STS_EXT_ARB_BIT] = strap_q.ext_arb;
        rd_data[STS_LOCKED_BIT] = straps_locked;
        rd_data[STS_SMBUS_BIT] = smbus_mode_q;
        rd_data[STS_EEPROM_BIT] = eeprom_mode_q;
      end
      OFS_SMB_ADDR: rd_data[7:1] = smbus_target_addr_q;
      OFS_GPIO_OUT: rd_data[3:0] = gpio_out_q;
      OFS_GPIO_OE: rd_data[3:0] = gpio_oe_q;
      OFS_PIN_IN: begin
        rd_data[3:0] = filt_q.gpio;
        rd_data[PIN_IN_GEN_LSB +: 4] = strap_q.ext_arb ? filt_q.req_n : 4'h0;
      end
      OFS_GEN_OUT: rd_data[3:0] = gen_out_q;
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strap_hold: assert property (straps_locked |=> $stable(strap_q) && straps_locked)
    else $error("Straps changed after lock.");
  a_addr_fixed: assert property (smbus_mode_q |-> smbus_target_addr_q[7:5] == 3'h6)
    else $error("SMBus address fixed bits wrong.");
  a_addr_capture: assert property ($rose(straps_locked) && smbus_mode_q
    |-> smbus_target_addr_q[4:1] == $past(filt_q.gpio))
    else $error("SMBus address not taken from pins.");
  a_mode_select: assert property (straps_locked |-> smbus_mode_q ==
    (strap_q.mgmt_sel && !strap_q.test_hi) && !(smbus_mode_q && eeprom_mode_q))
    else $error("Management mode decode wrong.");
  a_smb_clock_in: assert property (smbus_mode_q |=> !mgmt_serial_clock_pin_oe)
    else $error("SMBus clock pin driven.");
  a_smb_data_od: assert property (mgmt_serial_data_pin_oe && smbus_mode_q
    |-> !mgmt_serial_data_pin_out)
    else $error("SMBus data driven high.");
  a_hp_pins: assert property (strap_q.hotplug && $stable(strap_q)
    |=> gpio_pin_oe[3:1] == $past(hp_core_oe))
    else $error("Hot-plug pins not routed.");
  a_gpo_route: assert property (strap_q.ext_arb && $stable(strap_q)
    |=> gnt_n_pin == $past(gen_out_q))
    else $error("General outputs not on grant pins.");
  a_gpi_route: assert property (strap_q.ext_arb |=> arb_core_req_n == 4'hf)
    else $error("Core still sees requests.");
  a_lock_time: assert property ($rose(aresetn) |-> ##[1:6] straps_locked)
    else $error("Straps not locked in time.");

  c_smbus: cover property ($rose(straps_locked) && smbus_mode_q);
  c_ext_arb: cover property ($rose(straps_locked) && strap_q.ext_arb);
  c_hotplug: cover property ($rose(straps_locked) && strap_q.hotplug);
  c_write: cover property (wr_fire ##[1:4] s_axi_bvalid && s_axi_bready);
endmodule

// ---- strap_board_model.sv ----
// Board model: strap resistors, pin loads and management bus pull-ups.
`timescale 1ns/100ps
module strap_board
  import strap_pin_pkg::*;
(
  // Board settings.
  input wire logic [3:0] strap_set,
  input wire logic [3:0] gpio_drive,
  // Device pins.
  input wire logic [3:0] gpio_pin_out,
  input wire logic [3:0] gpio_pin_oe,
  input wire logic mgmt_serial_clock_pin_out,
  input wire logic mgmt_serial_clock_pin_oe,
  input wire logic mgmt_serial_data_pin_out,
  input wire logic mgmt_serial_data_pin_oe,
  output logic hotplug_mask_strap,
  output logic mgmt_bus_select_strap,
  output logic test_mode_strap_hi,
  output logic ext_arbiter_select_strap,
  output logic [3:0] gpio_pin_in,
  output logic mgmt_serial_clock_pin_in,
  output logic mgmt_serial_data_pin_in
);
  assign {hotplug_mask_strap, mgmt_bus_select_strap} = strap_set[3:2];
  assign {test_mode_strap_hi, ext_arbiter_select_strap} = strap_set[1:0];
  assign gpio_pin_in = (gpio_pin_oe & gpio_pin_out) | (~gpio_pin_oe & gpio_drive);
  // The host clock stands still, so each line shows its pull-up unless the device pulls it.
  assign mgmt_serial_clock_pin_in = ~(mgmt_serial_clock_pin_oe & ~mgmt_serial_clock_pin_out);
  assign mgmt_serial_data_pin_in = ~(mgmt_serial_data_pin_oe & ~mgmt_serial_data_pin_out);
endmodule

// ---- strap_pin_function_select_tb_top.sv ----
// Self-checking bench for the strap-controlled pin function block.
`timescale 1ns/100ps
`define CHK(nm, e, v) begin \
  compares++; \
  if ((v) !== (e)) begin \
    num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, v); \
  end \
end
module strap_pin_function_select_tb_top
  import strap_pin_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, gpio_pin_in, gpio_pin_out, gpio_pin_oe, strap_set, gpio_drive;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic hotplug_mask_strap, mgmt_bus_select_strap, test_mode_strap_hi, ext_arbiter_select_strap;
  logic [5:2] req_n_pin, gnt_n_pin, arb_core_gnt_n, arb_core_req_n;
  logic mgmt_serial_clock_pin_in, mgmt_serial_clock_pin_out, mgmt_serial_clock_pin_oe;
  logic mgmt_serial_data_pin_in, mgmt_serial_data_pin_out, mgmt_serial_data_pin_oe;
  logic [3:1] hp_core_out, hp_core_oe, hp_core_in;
  logic mgmt_core_clock_out, mgmt_core_data_out, mgmt_core_data_oe, mgmt_core_clock_in;
  logic mgmt_core_data_in, smbus_mode_q, eeprom_mode_q, straps_locked, smb;
  logic [7:1] smbus_target_addr_q;
  strap_type strap_q;
  int num_errors = 0, compares = 0, cyc = 0;
  logic [31:0] seed = 32'h48, r, v, d;
  logic [3:0] s, p;

  strap_pin_function_select dut_u (.*);
  strap_board board_u (.*);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Pin levels seen on the board: hot-plug drivers win where enabled.
  function automatic logic [3:0] pins_exp(logic [3:0] st, logic [3:0] g, logic [3:0] o,
                                          logic [3:0] e);
    logic [3:0] q;
    q = g;
    for (int i = 0; i < 4; i++) begin
      if (i > 0 && st[3]) begin
        if (hp_core_oe[i]) q[i] = hp_core_out[i];
      end else if (e[i]) begin
        q[i] = o[i];
      end
    end
    return q;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, strap_set, gpio_drive, req_n_pin} = '0;
    {hp_core_out, hp_core_oe, arb_core_gnt_n, mgmt_core_clock_out} = '0;
    {mgmt_core_data_out, mgmt_core_data_oe} = '0;
    s_axi_wstrb = 4'hf;
    for (int it = 0; it < 12; it++) begin
      r = rnd();
      s = (it == 0) ? 4'hd : (it == 1) ? 4'h0 : r[3:0];
      @(posedge aclk);
      aresetn <= 1'b0;
      strap_set <= s;
      gpio_drive <= r[7:4];
      req_n_pin <= r[11:8];
      {hp_core_out, hp_core_oe} <= r[17:12];
      arb_core_gnt_n <= r[21:18];
      {mgmt_core_clock_out, mgmt_core_data_out, mgmt_core_data_oe} <= r[24:22];
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int k = 0; k < 20 && straps_locked !== 1'b1; k++) @(posedge aclk);
      `CHK("locked", 1'b1, straps_locked)
      strap_set <= ~s;
      repeat (12) @(posedge aclk);
      smb = s[2] & ~s[1];
      p = pins_exp(s, r[7:4], 4'h0, 4'h0);
      rd(OFS_STRAP_STATUS);
      `CHK("status", {25'h0, ~s[2] & ~s[1], smb, 1'b1, s[0], s[1], s[2], s[3]}, d)
      `CHK("straps", s, strap_q)
      rd(OFS_SMB_ADDR);
      `CHK("address", smb ? {24'h0, 3'b110, r[7:4], 1'b0} : 32'h0, d)
      `CHK("address port", smb ? {3'b110, r[7:4]} : 7'h0, smbus_target_addr_q)
      rd(OFS_PIN_IN);
      `CHK("pin input", {24'h0, s[0] ? req_n_pin : 4'h0, p}, d)
      `CHK("hot-plug in", s[3] ? p[3:1] : 3'h0, hp_core_in)
      `CHK("request", s[0] ? 4'hf : req_n_pin, arb_core_req_n)
      v = rnd();
      wr(OFS_GEN_OUT, v);
      `CHK("write resp", RESP_OKAY, rs)
      wr(OFS_GPIO_OUT, v >> 4);
      repeat (2) @(posedge aclk);
      `CHK("grant", s[0] ? v[3:0] : arb_core_gnt_n, gnt_n_pin)
      `CHK("hot-plug oe", s[3] ? hp_core_oe : 3'h0, gpio_pin_oe[3:1])
      `CHK("hot-plug out", s[3] ? hp_core_out : v[7:5], gpio_pin_out[3:1])
      if (smb) begin
        `CHK("clock oe", 1'b0, mgmt_serial_clock_pin_oe)
        `CHK("data out", 1'b0, mgmt_serial_data_pin_out)
        `CHK("data oe", r[22] & ~r[23], mgmt_serial_data_pin_oe)
        `CHK("data in", ~(r[22] & ~r[23]), mgmt_core_data_in)
      end else begin
        `CHK("clock oe", ~s[1], mgmt_serial_clock_pin_oe)
        `CHK("clock out", ~s[1] & r[24], mgmt_serial_clock_pin_out)
        `CHK("data oe", ~s[1] & r[22], mgmt_serial_data_pin_oe)
        `CHK("data out", ~s[1] & r[23], mgmt_serial_data_pin_out)
      end
      `CHK("clock in", ~(~s[2] & ~s[1] & ~r[24]), mgmt_core_clock_in)
      wr(OFS_GPIO_OE, v >> 8);
      `CHK("oe write resp", RESP_OKAY, rs)
      rd(OFS_GPIO_OE);
      `CHK("oe readback", {28'h0, v[11:8]}, d)
      rd(OFS_GEN_OUT);
      `CHK("general readback", {28'h0, v[3:0]}, d)
      repeat (6) @(posedge aclk);
      p = pins_exp(s, r[7:4], v[7:4], v[11:8]);
      rd(OFS_PIN_IN);
      `CHK("pins driven", {24'h0, s[0] ? req_n_pin : 4'h0, p}, d)
      `CHK("pin oe", {(s[3] ? hp_core_oe : v[11:9]), v[8]}, gpio_pin_oe)
      `CHK("pin out", {(s[3] ? hp_core_out : v[7:5]), v[4]}, gpio_pin_out)
      `CHK("address held", smb ? {3'b110, r[7:4]} : 7'h0, smbus_target_addr_q)
      wr(8'h40, v);
      `CHK("unmapped write", RESP_SLVERR, rs)
      rd(8'h40);
      `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {rs, d})
    end
    results();
  end
endmodule
